// ### verilog/wapt_pkg.sv
// Package of constants for the channel 7 window alert and peak tracker
// Functional notes
// R1 - High threshold low nibble sits in hysteresis register bits 7:4, meets result bits 3:0
// R2 - Low threshold low nibble sits in debounce register bits 7:4, meets result bits 3:0
// R3 - Each threshold top byte compares against result bits 11:4
// R4 - Hysteresis nibble shifted left three, zero filled, adjusts both thresholds' lower bits
// R5 - Alert sets after count plus one consecutive out-of-window samples
// R6 - Peak registers hold largest code for channels 0 and 1 since last high byte read
// R7 - Reading a peak register returns its value, then clears it to zero
// R8 - Any in-window channel 7 sample restarts the consecutive-sample counter from zero
package wapt_pkg;
    // ****************************************************************
    // Register indices and byte addresses
    // ****************************************************************
    localparam int unsigned IDX_HYST_HI_NIB   = 32'h0000003C;
    localparam int unsigned IDX_HI_TOP        = 32'h0000003D;
    localparam int unsigned IDX_LO_NIB_DEB    = 32'h0000003E;
    localparam int unsigned IDX_LO_TOP        = 32'h0000003F;
    localparam int unsigned IDX_PEAK0_LOW     = 32'h00000060;
    localparam int unsigned IDX_PEAK0_HIGH    = 32'h00000061;
    localparam int unsigned IDX_PEAK1_LOW     = 32'h00000062;
    localparam int unsigned IDX_PEAK1_HIGH    = 32'h00000063;
    localparam int unsigned IDX_ALERT_STATUS  = 32'h00000070;
    localparam int unsigned ADDR_WIDTH        = 32'h0000000A;
    localparam int unsigned BYTES_PER_WORD    = 32'h00000004;
    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] RST_HYST_HI_NIB    = 8'hF0;
    localparam logic [7:0] RST_HI_TOP         = 8'hFF;
    localparam logic [7:0] RST_LO_NIB_DEB     = 8'h00;
    localparam logic [7:0] RST_LO_TOP         = 8'h00;
    // ****************************************************************
    // Field positions and widths
    // ****************************************************************
    localparam int unsigned CODE_WIDTH        = 32'h0000000C;
    localparam int unsigned NIB_HI            = 32'h00000007;
    localparam int unsigned NIB_LO            = 32'h00000004;
    localparam int unsigned FIELD_HI          = 32'h00000003;
    localparam int unsigned FIELD_LO          = 32'h00000000;
    localparam int unsigned HYST_SHIFT        = 32'h00000003;
    localparam int unsigned ALERT_BIT         = 32'h00000000;
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;
endpackage

// ### verilog/wapt_window_alert.sv
// Channel 7 window comparator with debounce, peak trackers and AXI4-Lite slave
`timescale 1ns/1ps
module wapt_window_alert #(
    parameter int unsigned ALERT_CHANNEL = 32'h00000007,
    parameter int unsigned PEAK_CHANNELS = 32'h00000002
) (
    input  wire logic                                 core_clk,
    input  wire logic                                 reset_n,
    input  wire logic                                 sampleValid,
    input  wire logic [2:0]                           sampleChannel,
    input  wire logic [wapt_pkg::CODE_WIDTH-1:0]      sampleCode,
    output logic                                      alertFlag,
    input  wire logic [wapt_pkg::ADDR_WIDTH-1:0]      s_axi_awaddr,
    input  wire logic                                 s_axi_awvalid,
    output logic                                      s_axi_awready,
    input  wire logic [31:0]                          s_axi_wdata,
    input  wire logic [3:0]                           s_axi_wstrb,
    input  wire logic                                 s_axi_wvalid,
    output logic                                      s_axi_wready,
    output logic [1:0]                                s_axi_bresp,
    output logic                                      s_axi_bvalid,
    input  wire logic                                 s_axi_bready,
    input  wire logic [wapt_pkg::ADDR_WIDTH-1:0]      s_axi_araddr,
    input  wire logic                                 s_axi_arvalid,
    output logic                                      s_axi_arready,
    output logic [31:0]                               s_axi_rdata,
    output logic [1:0]                                s_axi_rresp,
    output logic                                      s_axi_rvalid,
    input  wire logic                                 s_axi_rready
);
    localparam int unsigned CW = wapt_pkg::CODE_WIDTH;
    localparam logic [wapt_pkg::ADDR_WIDTH-1:0] A_HYST =
        wapt_pkg::ADDR_WIDTH'(wapt_pkg::IDX_HYST_HI_NIB * wapt_pkg::BYTES_PER_WORD);
    localparam logic [wapt_pkg::ADDR_WIDTH-1:0] A_HITOP =
        wapt_pkg::ADDR_WIDTH'(wapt_pkg::IDX_HI_TOP * wapt_pkg::BYTES_PER_WORD);
    localparam logic [wapt_pkg::ADDR_WIDTH-1:0] A_LODEB =
        wapt_pkg::ADDR_WIDTH'(wapt_pkg::IDX_LO_NIB_DEB * wapt_pkg::BYTES_PER_WORD);
    localparam logic [wapt_pkg::ADDR_WIDTH-1:0] A_LOTOP =
        wapt_pkg::ADDR_WIDTH'(wapt_pkg::IDX_LO_TOP * wapt_pkg::BYTES_PER_WORD);
    localparam logic [wapt_pkg::ADDR_WIDTH-1:0] A_STAT =
        wapt_pkg::ADDR_WIDTH'(wapt_pkg::IDX_ALERT_STATUS * wapt_pkg::BYTES_PER_WORD);

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    logic [7:0]                      hystHiNib_q;
    logic [7:0]                      hiTop_q;
    logic [7:0]                      loNibDeb_q;
    logic [7:0]                      loTop_q;
    logic [3:0]                      debCount_q;
    logic                            alert_q;
    logic [3:0]                      ch7_debounce_count;
    logic [3:0]                      ch7_hyst_nibble;
    logic [CW-1:0]                   upperLimit;
    logic [CW-1:0]                   lowerLimit;
    logic [6:0]                      hystAmount;
    logic [CW-1:0]                   upperEff;
    logic [CW-1:0]                   lowerEff;
    logic [CW:0]                     lowerSum;
    logic                            outOfWindow;
    logic                            alertSample;
    logic                            alertClear;

    // ****************************************************************
    // AXI4-Lite write path
    // ****************************************************************
    logic                            awHeld_q;
    logic                            wHeld_q;
    logic [wapt_pkg::ADDR_WIDTH-1:0] awAddr_q;
    logic [7:0]                      wByte_q;
    logic                            wLane0_q;
    logic                            doWrite;
    logic                            writeHit;
    logic [wapt_pkg::ADDR_WIDTH-1:0] wordAw;

    // Address and data are taken independently; the response waits for both
    assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
    assign doWrite       = awHeld_q && wHeld_q && !s_axi_bvalid;
    assign wordAw        = {awAddr_q[wapt_pkg::ADDR_WIDTH-1:2], 2'b00};
    assign writeHit      = (wordAw == A_HYST) || (wordAw == A_HITOP) || (wordAw == A_LODEB)
                        || (wordAw == A_LOTOP) || (wordAw == A_STAT)
                        || (wordAw >= peakAddr(0) && wordAw <= peakAddr(3));

    function automatic logic [wapt_pkg::ADDR_WIDTH-1:0] peakAddr(input int unsigned k);
        peakAddr = wapt_pkg::ADDR_WIDTH'((wapt_pkg::IDX_PEAK0_LOW + k)
                 * wapt_pkg::BYTES_PER_WORD);
    endfunction

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            awHeld_q <= 1'b0;
            awAddr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
        end else if (doWrite) begin
            awHeld_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wHeld_q  <= 1'b0;
            wByte_q  <= 8'h00;
            wLane0_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q  <= 1'b1;
            wByte_q  <= s_axi_wdata[7:0];
            wLane0_q <= s_axi_wstrb[0];
        end else if (doWrite) begin
            wHeld_q  <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= wapt_pkg::RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= writeHit ? wapt_pkg::RESP_OKAY : wapt_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Only byte lane 0 carries register data; other lanes are ignored
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            hystHiNib_q <= wapt_pkg::RST_HYST_HI_NIB;
            hiTop_q     <= wapt_pkg::RST_HI_TOP;
            loNibDeb_q  <= wapt_pkg::RST_LO_NIB_DEB;
            loTop_q     <= wapt_pkg::RST_LO_TOP;
        end else if (doWrite && wLane0_q) begin
            if (wordAw == A_HYST) begin
                hystHiNib_q <= wByte_q;
            end else if (wordAw == A_HITOP) begin
                hiTop_q <= wByte_q;
            end else if (wordAw == A_LODEB) begin
                loNibDeb_q <= wByte_q;
            end else if (wordAw == A_LOTOP) begin
                loTop_q <= wByte_q;
            end
        end
    end

    assign alertClear = doWrite && wLane0_q && (wordAw == A_STAT) && wByte_q[wapt_pkg::ALERT_BIT];

    // ****************************************************************
    // Window comparator
    // ****************************************************************
    assign ch7_hyst_nibble    = hystHiNib_q[wapt_pkg::FIELD_HI:wapt_pkg::FIELD_LO];
    assign ch7_debounce_count = loNibDeb_q[wapt_pkg::FIELD_HI:wapt_pkg::FIELD_LO];
    assign upperLimit = {hiTop_q, hystHiNib_q[wapt_pkg::NIB_HI:wapt_pkg::NIB_LO]}; // R1 R3
    assign lowerLimit = {loTop_q, loNibDeb_q[wapt_pkg::NIB_HI:wapt_pkg::NIB_LO]}; // R2 R3
    assign hystAmount = {ch7_hyst_nibble, {wapt_pkg::HYST_SHIFT{1'b0}}}; // R4
    assign lowerSum   = {1'b0, lowerLimit} + {{(CW-6){1'b0}}, hystAmount};

    // Hysteresis narrows the window while the alert stands, so a code
    // hovering on a threshold does not chatter; limits saturate at the code range
    always_comb begin
        upperEff = upperLimit;
        lowerEff = lowerLimit;
        if (alert_q) begin
            upperEff = (upperLimit > CW'(hystAmount)) ? upperLimit - CW'(hystAmount)
                                                      : '0; // R4
            lowerEff = lowerSum[CW] ? '1 : lowerSum[CW-1:0]; // R4
        end
    end

    assign outOfWindow = (sampleCode > upperEff) || (sampleCode < lowerEff);
    assign alertSample = sampleValid && (sampleChannel == 3'(ALERT_CHANNEL));

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            debCount_q <= 4'h0;
        end else if (alertSample) begin
            if (!outOfWindow) begin
                debCount_q <= 4'h0; // R8
            end else if (debCount_q < ch7_debounce_count) begin
                debCount_q <= debCount_q + 4'h1; // R5
            end
        end
    end

    // A new event in the clearing cycle wins over the clear
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            alert_q <= 1'b0;
        end else if (alertSample && outOfWindow && debCount_q >= ch7_debounce_count) begin
            alert_q <= 1'b1; // R5
        end else if (alertClear) begin
            alert_q <= 1'b0;
        end
    end

    assign alertFlag = alert_q;

    // ****************************************************************
    // AXI4-Lite read path and peak trackers
    // ****************************************************************
    logic [wapt_pkg::ADDR_WIDTH-1:0] wordAr;
    logic                            readTake;
    logic [PEAK_CHANNELS-1:0]        readHigh;
    logic [PEAK_CHANNELS-1:0]        readLow;
    logic [CW-1:0]                   peak_q [PEAK_CHANNELS];
    logic [3:0]                      peakShadow_q [PEAK_CHANNELS];

    assign s_axi_arready = !s_axi_rvalid;
    assign readTake      = s_axi_arvalid && s_axi_arready;
    assign wordAr        = {s_axi_araddr[wapt_pkg::ADDR_WIDTH-1:2], 2'b00};

    genvar ch;
    generate
        for (ch = 0; ch < PEAK_CHANNELS; ch++) begin : gPeak
            assign readLow[ch]  = readTake && (wordAr == peakAddr(2 * ch));
            assign readHigh[ch] = readTake && (wordAr == peakAddr(2 * ch + 1));
            // High byte read empties the tracker and parks the low nibble for the
            // following low byte read, so the pair stays coherent
            always_ff @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    peak_q[ch] <= '0;
                end else if (sampleValid && sampleChannel == 3'(ch)
                             && (readHigh[ch] || sampleCode > peak_q[ch])) begin
                    peak_q[ch] <= sampleCode; // R6
                end else if (readHigh[ch]) begin
                    peak_q[ch] <= '0; // R7
                end
            end
            always_ff @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    peakShadow_q[ch] <= 4'h0;
                end else if (readHigh[ch]) begin
                    peakShadow_q[ch] <= peak_q[ch][3:0];
                end else if (readLow[ch]) begin
                    peakShadow_q[ch] <= 4'h0; // R7
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= wapt_pkg::RESP_OKAY;
        end else if (readTake) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= wapt_pkg::RESP_OKAY;
            if (wordAr == A_HYST) begin
                s_axi_rdata <= {24'h000000, hystHiNib_q};
            end else if (wordAr == A_HITOP) begin
                s_axi_rdata <= {24'h000000, hiTop_q};
            end else if (wordAr == A_LODEB) begin
                s_axi_rdata <= {24'h000000, loNibDeb_q};
            end else if (wordAr == A_LOTOP) begin
                s_axi_rdata <= {24'h000000, loTop_q};
            end else if (wordAr == A_STAT) begin
                s_axi_rdata <= {24'h000000, debCount_q, 3'b000, alert_q};
            end else if (wordAr == peakAddr(0)) begin
                s_axi_rdata <= {24'h000000, peakShadow_q[0], 4'h0}; // R7
            end else if (wordAr == peakAddr(1)) begin
                s_axi_rdata <= {24'h000000, peak_q[0][CW-1:4]}; // R7
            end else if (wordAr == peakAddr(2)) begin
                s_axi_rdata <= {24'h000000, peakShadow_q[1], 4'h0}; // R7
            end else if (wordAr == peakAddr(3)) begin
                s_axi_rdata <= {24'h000000, peak_q[1][CW-1:4]}; // R7
            end else begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= wapt_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // wapt_window_alert

// ### sim/wapt_window_alert_monitor.sv
// Port checker for the window alert and peak tracker
`timescale 1ns/1ps
module wapt_window_alert_monitor (
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic        sampleValid,
    input wire logic [2:0]  sampleChannel,
    input wire logic        alertFlag,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [9:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    // ****
    // Checks
    // ****
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic arMapped;
    assign arMapped = s_axi_araddr inside {10'h0F0, 10'h0F4, 10'h0F8, 10'h0FC, 10'h180,
                                           10'h184, 10'h188, 10'h18C, 10'h1C0};
    AST_ALERT_CAUSE:
    assert property ($rose(alertFlag) |-> $past(sampleValid) && $past(sampleChannel) == 3'h7)
        else $error("alert rose without a channel 7 sample");
    AST_ALERT_STICKY:
    assert property ($fell(alertFlag) |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2)
        || $past(s_axi_wvalid, 3)) else $error("alert dropped without a write");
    AST_WR_ANSWER:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
    AST_WR_HOLD:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    AST_WR_REFUSE:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    AST_RD_OK:
    assert property (s_axi_arvalid && s_axi_arready && arMapped
        |-> ##[1:2] (s_axi_rvalid && s_axi_rresp == wapt_pkg::RESP_OKAY))
        else $error("mapped read not answered okay");
    AST_RD_UNMAPPED:
    assert property (s_axi_arvalid && s_axi_arready && !arMapped |-> ##[1:2] (s_axi_rvalid
        && s_axi_rresp == wapt_pkg::RESP_SLVERR && s_axi_rdata == 32'h0))
        else $error("unmapped read not refused");
    AST_RD_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    AST_RD_BYTE:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    AST_RD_REFUSE:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
endmodule // wapt_window_alert_monitor

// ### sim/window_alert_and_peak_tracker_tb_top.sv
// Self-checking bench for the window alert and peak tracker
`timescale 1ns/1ps
module window_alert_and_peak_tracker_tb_top;
    typedef struct packed {
        logic [1:0]  op;
        logic [9:0]  addr;
        logic [31:0] data;
        logic [7:0]  exp;
    } wapt_row_s;
    logic        coreClk, resetN, smpValid, alertFlag;
    logic [2:0]  smpChan;
    logic [11:0] smpCode;
    logic [9:0]  awAddr, arAddr;
    logic [31:0] wData, rData, data;
    logic [3:0]  wStrb;
    logic [1:0]  bResp, rResp, resp;
    logic        awValid, awReady, wValid, wReady, bValid, bReady;
    logic        arValid, arReady, rValid, rReady;
    int          miscompares = 0;
    int          numChecks = 0;
    // Ops: 0 read, 1 write, 2 write with no strobes, 3 sample
    wapt_row_s   rows [38] = '{
        '{2'h0, 10'h0F0, 32'h0, 8'hF0}, '{2'h0, 10'h0F4, 32'h0, 8'hFF},
        '{2'h0, 10'h0F8, 32'h0, 8'h00}, '{2'h0, 10'h0FC, 32'h0, 8'h00},
        '{2'h1, 10'h0F4, 32'hABCDEF80, 8'h00}, '{2'h0, 10'h0F4, 32'h0, 8'h80},
        '{2'h2, 10'h0F8, 32'h55, 8'h00}, '{2'h0, 10'h0F8, 32'h0, 8'h00},
        '{2'h1, 10'h0F0, 32'h51, 8'h00}, '{2'h1, 10'h0F8, 32'h32, 8'h00},
        '{2'h1, 10'h0FC, 32'h20, 8'h00}, '{2'h3, 10'h007, 32'h806, 8'h00},
        '{2'h3, 10'h007, 32'h805, 8'h00}, '{2'h3, 10'h007, 32'h806, 8'h00},
        '{2'h3, 10'h007, 32'h806, 8'h00}, '{2'h3, 10'h007, 32'h203, 8'h00},
        '{2'h3, 10'h007, 32'h202, 8'h00}, '{2'h3, 10'h007, 32'h202, 8'h00},
        '{2'h3, 10'h003, 32'hFFF, 8'h00}, '{2'h3, 10'h007, 32'h202, 8'h01},
        '{2'h3, 10'h007, 32'h800, 8'h01}, '{2'h0, 10'h1C0, 32'h0, 8'h21},
        '{2'h3, 10'h007, 32'h7FC, 8'h01}, '{2'h0, 10'h1C0, 32'h0, 8'h01},
        '{2'h1, 10'h1C0, 32'h1, 8'h00}, '{2'h3, 10'h007, 32'h7FC, 8'h00},
        '{2'h3, 10'h000, 32'h3A7, 8'h00}, '{2'h3, 10'h000, 32'h5C2, 8'h00},
        '{2'h3, 10'h000, 32'h4FF, 8'h00}, '{2'h3, 10'h001, 32'h123, 8'h00},
        '{2'h0, 10'h184, 32'h0, 8'h5C}, '{2'h0, 10'h180, 32'h0, 8'h20},
        '{2'h0, 10'h184, 32'h0, 8'h00}, '{2'h0, 10'h180, 32'h0, 8'h00},
        '{2'h0, 10'h18C, 32'h0, 8'h12}, '{2'h0, 10'h188, 32'h0, 8'h30},
        '{2'h3, 10'h000, 32'h011, 8'h00}, '{2'h0, 10'h184, 32'h0, 8'h01}};

    wapt_window_alert dut (
        .core_clk(coreClk), .reset_n(resetN), .sampleValid(smpValid),
        .sampleChannel(smpChan), .sampleCode(smpCode), .alertFlag(alertFlag),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady));

    initial begin
        coreClk = 1'b0;
        forever #20 coreClk = ~coreClk;
    end
    // ****
    // Tasks
    // ****
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        numChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic endOfTest();
        $display("checks %0d mismatches %0d", numChecks, miscompares);
        if (miscompares == 0 && numChecks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Ready is raised late on purpose so the slave must hold its answer
    task automatic axi(input logic wr, input logic [9:0] a, input logic [3:0] s,
                       input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge coreClk);
        awAddr  <= a;
        arAddr  <= a;
        wData   <= d;
        wStrb   <= s;
        awValid <= wr;
        wValid  <= wr;
        arValid <= !wr;
        do begin
            @(posedge coreClk);
            n++;
            if (awReady) awValid <= 1'b0;
            if (wReady) wValid <= 1'b0;
            if (arReady) arValid <= 1'b0;
            if (n == 3) begin
                bReady <= wr;
                rReady <= !wr;
            end
        end while (!(bValid && bReady) && !(rValid && rReady) && n < 40);
        q = rData;
        r = wr ? bResp : rResp;
        bReady <= 1'b0;
        rReady <= 1'b0;
        if (n >= 40) begin
            miscompares++;
            endOfTest();
        end
    endtask
    task automatic feed(input logic [2:0] ch, input logic [11:0] code);
        @(posedge coreClk);
        smpValid <= 1'b1;
        smpChan  <= ch;
        smpCode  <= code;
        @(posedge coreClk);
        smpValid <= 1'b0;
        #1;
    endtask

    initial begin
        {resetN, smpValid, awValid, wValid, bReady, arValid, rReady} = 7'h00;
        {smpChan, smpCode, awAddr, arAddr, wData, wStrb} = 71'h0;
        repeat (16) @(posedge coreClk);
        resetN <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].op == 2'h3) begin
                feed(rows[i].addr[2:0], rows[i].data[11:0]);
                check("alert flag", 32'(rows[i].exp), 32'(alertFlag));
            end else begin
                axi(rows[i].op != 2'h0, rows[i].addr, (rows[i].op == 2'h1) ? 4'hF : 4'h0,
                    rows[i].data, data, resp);
                check("register", 32'(rows[i].exp), (rows[i].op == 2'h0) ? data : 32'(resp));
            end
        end
        $display("row table test done");
        axi(1'b0, 10'h100, 4'h0, 32'h0, data, resp);
        check("unmapped read", {30'h0, wapt_pkg::RESP_SLVERR}, {30'h0, resp});
        check("unmapped data", 32'h0, data);
        axi(1'b1, 10'h104, 4'hF, 32'h1, data, resp);
        check("unmapped write", {30'h0, wapt_pkg::RESP_SLVERR}, {30'h0, resp});
        $display("unmapped test done");
        feed(3'h1, 12'h0AB);
        axi(1'b0, 10'h18C, 4'h0, 32'h0, data, resp);
        check("peak high byte", 32'h0A, data);
        axi(1'b0, 10'h18C, 4'h0, 32'h0, data, resp);
        check("peak after read", 32'h00, data);
        $display("peak test done");
        axi(1'b1, 10'h0F8, 4'hF, 32'h0, data, resp);
        feed(3'h7, 12'hFFF);
        check("single sample alert", 32'h1, 32'(alertFlag));
        @(posedge coreClk);
        resetN <= 1'b0;
        repeat (4) @(posedge coreClk);
        check("alert in reset", 32'h0, 32'(alertFlag));
        resetN <= 1'b1;
        axi(1'b0, 10'h0F0, 4'h0, 32'h0, data, resp);
        check("reset hysteresis reg", 32'hF0, data);
        $display("reset test done");
        endOfTest();
    end
endmodule // window_alert_and_peak_tracker_tb_top

bind wapt_window_alert wapt_window_alert_monitor mon (
    .core_clk(core_clk), .reset_n(reset_n), .sampleValid(sampleValid),
    .sampleChannel(sampleChannel), .alertFlag(alertFlag), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_rdata(s_axi_rdata),
    .s_axi_arready(s_axi_arready), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
